// ===== bbcr_bus_model.sv
// far-side bus traffic as reported by the byte engine
`timescale 1ns/1ps
module bbcr_bus_model (
   // clock
   input  wire logic clk,
   // one event per cycle and its qualifiers
   output logic [6:0] ev,
   output logic       acked,
   output logic       dir_read
);
   initial {ev, acked, dir_read} = 9'h000;
   // called just after an edge; held until the next edge has taken it
   task automatic put(input logic [6:0] e, input logic a, input logic r);
      ev = e;
      acked = a;
      dir_read = r;
      @(posedge clk) #10;
   endtask
   // stale qualifiers are inverted so a late sample cannot match by luck
   task automatic rest();
      ev = 7'h00;
      acked = ~acked;
      dir_read = ~dir_read;
   endtask
endmodule // bbcr_bus_model

// ===== bbcr_count.sv
// buffered byte-count reporting logic of the i2c controller
`timescale 1ns/1ps
module bbcr_count #(
   parameter int DEPTH = bbcr_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic                     REF_CLK,
   input  wire logic                     RST_N,
   // host register strobes
   input  wire logic                     CNT_WR,
   input  wire logic [bbcr_pkg::CNT_W-1:0] CNT_WDATA,
   input  wire logic                     CON_WR,
   input  wire logic                     CON_MODE,
   input  wire logic                     DAT_ACCESS,
   // byte engine events
   input  wire logic                     EV_START,
   input  wire logic                     EV_STOP,
   input  wire logic                     EV_ADDR,
   input  wire logic                     EV_DATA,
   input  wire logic                     EV_ACKED,
   input  wire logic                     EV_DIR_READ,
   input  wire logic                     EV_ARB_LOST,
   input  wire logic                     EV_SLAVE_SEL,
   input  wire logic                     EV_SLAVE_END,
   // host visible state
   output logic [bbcr_pkg::CNT_W-1:0]    COUNT_READ,
   output logic                          SI_FLAG,
   output logic [7:0]                    STATUS_CODE,
   output logic                          STATUS_LOAD,
   output logic [bbcr_pkg::PTR_W-1:0]    BUF_PTR,
   // byte engine control
   output logic                          XFER_GO,
   output logic                          ACK_NEXT
);
   import bbcr_pkg::*;

   function automatic logic [BC_W-1:0] inc7(input logic [BC_W-1:0] v);
      inc7 = v + 1'b1;
   endfunction

   function automatic logic bc_bad(input logic [BC_W-1:0] v);
      bc_bad = (v == BC_ZERO) || (v > BC_MAX);
   endfunction

   bbcr_state_type      state;
   bbcr_state_type      next_state;
   bbcr_state_type      role;
   bbcr_state_type      next_role;
   logic [BC_W-1:0]     bc;
   logic [BC_W-1:0]     next_bc;
   logic                lb;
   logic                next_lb;
   logic [BC_W-1:0]     tally;
   logic [BC_W-1:0]     next_tally;
   logic [BC_W-1:0]     count;
   logic [BC_W-1:0]     next_count;
   logic                pend;
   logic                next_pend;
   logic                si;
   logic                next_si;
   logic [7:0]          sta;
   logic [7:0]          next_sta;
   logic                sta_ld;
   logic                next_sta_ld;
   logic                go;
   logic                next_go;
   logic                ack;
   logic                next_ack;
   logic                engine_step;
   logic [PTR_W-1:0]    ptr;
   logic [BC_W-1:0]     tally_inc;
   logic                con_ok;

   assign tally_inc   = inc7(tally);
   assign engine_step = EV_DATA | EV_ADDR;
   assign con_ok      = CON_WR & CON_MODE;

   // host data access and engine bytes both walk the same pointer
   bbcr_ptr #(
      .DEPTH (DEPTH)
   ) u_ptr (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .clear (CNT_WR),
      .step  (DAT_ACCESS | engine_step),
      .ptr   (ptr)
   );

   always_comb begin
      next_state  = state;
      next_role   = role;
      next_bc     = bc;
      next_lb     = lb;
      next_tally  = tally;
      next_count  = count;
      next_pend   = 1'b0;
      next_si     = si;
      next_sta    = sta;
      next_sta_ld = 1'b0;
      next_go     = 1'b0;
      // with lb set, the final byte of a receive run goes without acknowledge
      next_ack    = !(lb && (tally_inc == bc));

      if (CNT_WR) begin
         next_bc = CNT_WDATA[BC_W-1:0];
         next_lb = CNT_WDATA[LB_POS];
      end

      // clearing the flag loses against a flag being set this cycle
      if (con_ok) begin
         next_si = 1'b0;
      end
      if (pend) begin
         next_si = 1'b1;
      end

      case (state)
         BBCR_IDLE, BBCR_HOLD: begin
            if (con_ok && role != BBCR_IDLE) begin
               if (bc_bad(bc)) begin
                  next_sta    = STA_BAD_CNT;
                  next_sta_ld = 1'b1;
                  next_pend   = 1'b1;
               end else begin
                  next_go    = 1'b1;
                  next_tally = COUNT_RST;
                  next_state = role;
               end
            end
         end
         BBCR_MADR: begin
            if (EV_ARB_LOST) begin
               next_count = COUNT_RST;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
               next_role  = BBCR_IDLE;
            end else if (EV_ADDR && !EV_ACKED) begin
               next_count = TALLY_ONE;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
            end else if (EV_ADDR && EV_DIR_READ) begin
               next_tally = COUNT_RST;
               next_state = BBCR_MRX;
               next_role  = BBCR_MRX;
            end else if (EV_ADDR) begin
               next_tally = TALLY_ONE;
               next_role  = BBCR_MTX;
               if (bc == TALLY_ONE) begin
                  next_count = TALLY_ONE;
                  next_pend  = 1'b1;
                  next_state = BBCR_HOLD;
               end else begin
                  next_state = BBCR_MTX;
               end
            end
         end
         BBCR_MTX, BBCR_STX: begin
            // the tally already holds the address byte when it was sent
            if (EV_ARB_LOST) begin
               next_count = tally;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
               next_role  = BBCR_IDLE;
            end else if (EV_SLAVE_END) begin
               next_count = tally;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
               next_role  = BBCR_IDLE;
            end else if (EV_DATA) begin
               next_tally = tally_inc;
               if (!EV_ACKED || tally_inc == bc) begin
                  next_count = tally_inc;
                  next_pend  = 1'b1;
                  next_state = BBCR_HOLD;
                  if (!EV_ACKED && state == BBCR_STX) begin
                     next_role = BBCR_IDLE;
                  end
               end
            end
         end
         BBCR_MRX, BBCR_SRX: begin
            if (EV_ARB_LOST) begin
               // the byte was taken in before its ack was fought over
               next_count = tally_inc;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
               next_role  = BBCR_IDLE;
            end else if (EV_SLAVE_END) begin
               next_count = tally;
               next_pend  = 1'b1;
               next_state = BBCR_HOLD;
               next_role  = BBCR_IDLE;
            end else if (EV_DATA) begin
               next_tally = tally_inc;
               if (!EV_ACKED || tally_inc == bc) begin
                  next_count = tally_inc;
                  next_pend  = 1'b1;
                  next_state = BBCR_HOLD;
               end
            end
         end
         default: begin
            next_state = BBCR_IDLE;
            next_role  = BBCR_IDLE;
         end
      endcase

      // a selection as slave overrides whatever master work was pending
      if (EV_SLAVE_SEL) begin
         next_count = COUNT_RST;
         next_tally = COUNT_RST;
         next_pend  = 1'b1;
         next_state = BBCR_HOLD;
         next_role  = EV_DIR_READ ? BBCR_STX : BBCR_SRX;
      end
      // count is left as it stood; software must not trust it here
      if (EV_START) begin
         next_pend  = 1'b1;
         next_state = BBCR_HOLD;
         next_role  = BBCR_MADR;
      end
      if (EV_STOP) begin
         next_state = BBCR_IDLE;
         next_role  = BBCR_IDLE;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state  <= BBCR_IDLE;
         role   <= BBCR_IDLE;
         bc     <= COUNT_RST;
         lb     <= 1'b0;
         tally  <= COUNT_RST;
         count  <= COUNT_RST;
         pend   <= 1'b0;
         si     <= 1'b0;
         sta    <= STA_RST;
         sta_ld <= 1'b0;
         go     <= 1'b0;
         ack    <= 1'b1;
      end else begin
         state  <= next_state;
         role   <= next_role;
         bc     <= next_bc;
         lb     <= next_lb;
         tally  <= next_tally;
         count  <= next_count;
         pend   <= next_pend;
         si     <= next_si;
         sta    <= next_sta;
         sta_ld <= next_sta_ld;
         go     <= next_go;
         ack    <= next_ack;
      end
   end

   // count register shows the tally between sequences, the setup before
   logic [CNT_W-1:0] rd;
   logic [CNT_W-1:0] next_rd;

   always_comb begin
      next_rd = rd;
      if (CNT_WR) begin
         next_rd = CNT_WDATA;
      end else if (next_pend) begin
         // count lands with pend, so the flag rises a cycle later
         next_rd = {lb, next_count};
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd <= '0;
      end else begin
         rd <= next_rd;
      end
   end

   assign COUNT_READ  = rd;
   assign SI_FLAG     = si;
   assign STATUS_CODE = sta;
   assign STATUS_LOAD = sta_ld;
   assign BUF_PTR     = ptr;
   assign XFER_GO     = go;
   assign ACK_NEXT    = ack;
endmodule // bbcr_count

// ===== bbcr_count_properties.sv
// port checks of the byte-count reporter
`timescale 1ns/1ps
module bbcr_count_chk #(
   parameter int DEPTH = bbcr_pkg::BUF_DEPTH
) (
   // clock and reset
   input wire logic       REF_CLK,
   input wire logic       RST_N,
   // inputs of the block
   input wire logic       CNT_WR,
   input wire logic       CON_WR,
   input wire logic       CON_MODE,
   input wire logic       EV_ADDR,
   input wire logic       EV_STOP,
   input wire logic       EV_ACKED,
   input wire logic       EV_DIR_READ,
   // outputs of the block
   input wire logic [7:0] COUNT_READ,
   input wire logic       SI_FLAG,
   input wire logic [7:0] STATUS_CODE,
   input wire logic       STATUS_LOAD,
   input wire logic [6:0] BUF_PTR,
   input wire logic       XFER_GO
);
   import bbcr_pkg::*;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_bad_then_flag;
      STATUS_LOAD ##1 SI_FLAG;
   endsequence
   a_bad_code: assert property (
      STATUS_LOAD |-> STATUS_CODE == STA_BAD_CNT) else $error("bad code");
   a_bad_flag: assert property (
      STATUS_LOAD |-> s_bad_then_flag) else $error("no flag after bad count");
   a_bad_nogo: assert property (
      STATUS_LOAD |-> !XFER_GO ##1 !XFER_GO) else $error("bad count started");
   a_bad_cause: assert property (
      STATUS_LOAD |-> $past(CON_WR) && $past(CON_MODE)) else $error("stray load");
   a_ptr_clear: assert property (
      CNT_WR |=> BUF_PTR == 7'h00) else $error("pointer not cleared");
   a_flag_settled: assert property (
      $rose(SI_FLAG) |-> $stable(COUNT_READ)) else $error("count not settled");
   a_read_quiet: assert property (
      EV_ADDR && EV_DIR_READ && EV_ACKED |=> (!$rose(SI_FLAG)) [*3])
      else $error("flag on read address");
   a_stop_hold: assert property (
      EV_STOP && !CNT_WR |=> $stable(COUNT_READ)) else $error("count moved");
endmodule // bbcr_count_chk
bind bbcr_count bbcr_count_chk #(.DEPTH(DEPTH)) chk_u (.REF_CLK, .RST_N,
   .CNT_WR, .CON_WR, .CON_MODE, .EV_ADDR, .EV_STOP, .EV_ACKED, .EV_DIR_READ,
   .COUNT_READ, .SI_FLAG, .STATUS_CODE, .STATUS_LOAD, .BUF_PTR, .XFER_GO);

// ===== bbcr_pkg.sv
// shared constants and types of the buffered byte-count reporter
package bbcr_pkg;
   localparam int            BC_W        = 7;
   localparam int            CNT_W       = 8;
   localparam int            LB_POS      = 7;
   localparam int            BUF_DEPTH   = 68;
   localparam int            PTR_W       = 7;
   localparam logic [6:0]    BC_MAX      = 7'h44;
   localparam logic [6:0]    BC_ZERO     = 7'h00;
   localparam logic [6:0]    COUNT_RST   = 7'h00;
   localparam logic [6:0]    TALLY_ONE   = 7'h01;
   localparam logic [7:0]    STA_BAD_CNT = 8'hfc;
   localparam logic [7:0]    STA_RST     = 8'hf8;
   typedef enum logic [2:0] {
      BBCR_IDLE = 3'b000,
      BBCR_MADR = 3'b001,
      BBCR_MTX  = 3'b010,
      BBCR_MRX  = 3'b011,
      BBCR_SRX  = 3'b100,
      BBCR_STX  = 3'b101,
      BBCR_HOLD = 3'b110
   } bbcr_state_type;
endpackage

// ===== bbcr_ptr.sv
// buffer pointer with wrap at the buffer boundary
`timescale 1ns/1ps
module bbcr_ptr #(
   parameter int DEPTH = bbcr_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // control
   input  wire logic                     clear,
   input  wire logic                     step,
   // pointer
   output logic [bbcr_pkg::PTR_W-1:0]    ptr
);
   import bbcr_pkg::*;
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
   logic [PTR_W-1:0] next_ptr;

   // overrunning the buffer wraps onto the first byte, no protection
   always_comb begin
      next_ptr = ptr;
      if (clear) begin
         next_ptr = '0;
      end else if (step) begin
         next_ptr = (ptr == LAST) ? '0 : ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= '0;
      end else begin
         ptr <= next_ptr;
      end
   end
endmodule // bbcr_ptr

// ===== tb_top.sv
// self-checking bench of the byte-count reporter
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb_top;
   import bbcr_pkg::*;
   localparam logic [6:0] SRT = 7'h40, STP = 7'h20, ADR = 7'h10, DAT = 7'h08;
   localparam logic [6:0] ARB = 7'h04, SEL = 7'h02, SEND = 7'h01, NONE = 7'h00;
   logic       REF_CLK, RST_N, CNT_WR, CON_WR, CON_MODE, DAT_ACCESS, go_seen;
   logic       acked, dir_read, SI_FLAG, STATUS_LOAD, XFER_GO, ACK_NEXT;
   logic [6:0] ev, BUF_PTR;
   logic [7:0] CNT_WDATA, COUNT_READ, STATUS_CODE;
   logic [7:0] bad [3] = '{8'h00, 8'h45, 8'hff};
   int         errors = 0;
   int         check_count = 0;
   bbcr_count dut_u (.REF_CLK, .RST_N, .CNT_WR, .CNT_WDATA, .CON_WR, .CON_MODE,
      .DAT_ACCESS, .EV_START(ev[6]), .EV_STOP(ev[5]), .EV_ADDR(ev[4]),
      .EV_DATA(ev[3]), .EV_ARB_LOST(ev[2]), .EV_SLAVE_SEL(ev[1]),
      .EV_SLAVE_END(ev[0]), .EV_ACKED(acked), .EV_DIR_READ(dir_read),
      .COUNT_READ, .SI_FLAG, .STATUS_CODE, .STATUS_LOAD, .BUF_PTR, .XFER_GO,
      .ACK_NEXT);
   bbcr_bus_model bus_u (.clk(REF_CLK), .ev, .acked, .dir_read);
   task automatic cyc(input int n);
      repeat (n) @(posedge REF_CLK);
      #10;
   endtask
   task automatic host(input logic [7:0] c);
      CNT_WDATA = c;
      CNT_WR = 1'b1;
      cyc(1);
      CNT_WR = 1'b0;
      CON_WR = 1'b1;
      cyc(1);
      CON_WR = 1'b0;
      go_seen = 1'b0;
      repeat (3) begin
         go_seen |= XFER_GO;
         cyc(1);
      end
   endtask
   task automatic mstart(input logic [7:0] c);
      bus_u.put(STP, 1'b1, 1'b0);
      bus_u.put(SRT, 1'b1, 1'b0);
      bus_u.rest();
      cyc(2);
      host(c);
   endtask
   // one cycle lets the count land even when the flag is still up
   task automatic expect_count(input logic [7:0] x);
      cyc(1);
      for (int k = 0; k < 20 && SI_FLAG !== 1'b1; k++) cyc(1);
      `CHK(SI_FLAG, 1'b1)
      `CHK(COUNT_READ, x)
   endtask
   task automatic mrun(input logic [7:0] c, input logic [6:0] e1, e2, e3,
         input logic a, r, input logic [7:0] x);
      mstart(c);
      bus_u.put(e1, a, r);
      bus_u.put(e2, 1'b1, r);
      bus_u.put(e3, 1'b1, r);
      bus_u.rest();
      expect_count(x);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end
   initial begin
      #400000;
      errors++;
      finish_test();
   end
   initial begin
      {RST_N, CNT_WR, CON_WR, DAT_ACCESS, go_seen, CNT_WDATA} = 13'h0000;
      CON_MODE = 1'b1;
      cyc(5);
      RST_N = 1'b1;
      cyc(1);
      DAT_ACCESS = 1'b1;
      cyc(BUF_DEPTH + 1);
      DAT_ACCESS = 1'b0;
      cyc(1);
      `CHK(BUF_PTR, 7'h01)
      CNT_WR = 1'b1;
      cyc(1);
      CNT_WR = 1'b0;
      cyc(1);
      `CHK(BUF_PTR, 7'h00)
      mrun(8'h03, ADR, DAT, DAT, 1'b1, 1'b0, 8'h03);
      mrun(8'h01, ADR, NONE, NONE, 1'b1, 1'b0, 8'h01);
      mrun(8'h03, ADR, NONE, NONE, 1'b0, 1'b0, 8'h01);
      mrun(8'h03, ADR, NONE, NONE, 1'b0, 1'b1, 8'h01);
      mrun(8'h03, ARB, NONE, NONE, 1'b1, 1'b0, 8'h00);
      mrun(8'h03, ARB, NONE, NONE, 1'b1, 1'b1, 8'h00);
      mrun(8'h03, ADR, DAT, ARB, 1'b1, 1'b0, 8'h02);
      mrun(8'h82, ADR, DAT, DAT, 1'b1, 1'b1, 8'h82);
      mrun(8'h03, ADR, DAT, ARB, 1'b1, 1'b1, 8'h02);
      mstart(8'h81);
      `CHK(ACK_NEXT, 1'b0)
      mstart(8'h01);
      `CHK(ACK_NEXT, 1'b1)
      foreach (bad[i]) begin
         mstart(bad[i]);
         `CHK(go_seen, 1'b0)
         `CHK(SI_FLAG, 1'b1)
         `CHK(STATUS_CODE, STA_BAD_CNT)
      end
      mstart(8'h44);
      `CHK(go_seen, 1'b1)
      bus_u.put(STP, 1'b1, 1'b0);
      for (int r = 0; r < 2; r++) begin
         bus_u.put(SEL, 1'b1, r[0]);
         bus_u.rest();
         expect_count(8'h00);
         host(8'h02);
         bus_u.put(DAT, 1'b1, r[0]);
         bus_u.put(DAT, 1'b1, r[0]);
         bus_u.put(SEND, 1'b1, r[0]);
         bus_u.rest();
         expect_count(8'h02);
      end
      finish_test();
   end
endmodule // tb_top
